// >>> reset_seq_pkg.sv
// constants for the display reset sequencer
// assumes one 40 MHz clock; all times converted to cycles here
// Behaviour
// R1: low pulses shorter than 5us on reset line are ignored as spikes.
// R2: low longer than 9us always resets; 5us to 9us may reset.
// R3: spike rejection also applies inside a reset low period already running.
// R4: every reset release reloads id, common voltage and stored settings.
// R5: settings load finishes within 5ms after reset line rises.
// R6: reset while awake runs blanking sequence of at most 120ms.
// R7: reset while asleep keeps panel blank, then defaults restored.
// R8: reset cancel takes at most 5ms asleep, 120ms awake.
// R9: host sends no command until 5ms after releasing reset.
// R10: host sends no exit-sleep until 120ms after releasing reset.
// R11: command interface transactions ignored during reset and reload.
package reset_seq_pkg;
    localparam int unsigned CLK_HZ           = 40_000_000;
    localparam int unsigned SPIKE_NS         = 5_000;
    localparam int unsigned FILTER_NS        = 7_000;
    localparam int unsigned LOAD_MS          = 5;
    localparam int unsigned BLANK_MS         = 120;
    // least times round up
    localparam int unsigned SPIKE_CYC  = (SPIKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned FILTER_CYC = (FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // line release to timer start, plus the two exit states
    localparam int unsigned CANCEL_LAG_CYC = FILTER_CYC + 3;
    // longest times round down
    localparam int unsigned LOAD_CYC   = LOAD_MS * (CLK_HZ / 1000);
    localparam int unsigned BLANK_CYC  = BLANK_MS * (CLK_HZ / 1000);
    localparam int unsigned NVM_WORDS  = 8;
    localparam logic [7:0]  NVM_DEFAULT = 8'h00;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b000,
        ST_RESET  = 3'b001,
        ST_LOAD   = 3'b011,
        ST_BLANK  = 3'b010,
        ST_SETTLE = 3'b110
    } seq_state_t;
endpackage : reset_seq_pkg

// >>> reset_spike_filter.sv
// glitch filter for the active-low hardware reset line
// assumes input synchronous to clk; output changes only after a stable run
module reset_spike_filter
    import reset_seq_pkg::*;
#(
    parameter int unsigned FILT_CYC = FILTER_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic raw_n,
    output logic      clean_n
);
    logic [15:0] run;
    wire         differs  = raw_n != clean_n;
    wire         run_done = run >= 16'(FILT_CYC - 1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run     <= 16'h0000;
            clean_n <= 1'b1;
        end else if (ce) begin
            if (!differs) begin
                run <= 16'h0000; // R1 R3
            end else if (run_done) begin
                run     <= 16'h0000;
                clean_n <= raw_n; // R2
            end else begin
                run <= run + 16'h0001;
            end
        end
    end

    chk_spike_reject: assert property (@(posedge clk) disable iff (rst) // R1
        (ce && $fell(raw_n) && clean_n) ##1 (raw_n && ce)
        |-> ##1 clean_n)
        else $error("short low pulse caused reset");
    chk_long_low: assert property (@(posedge clk) disable iff (rst) // R2
        (ce && clean_n && run == 16'h0000 && !raw_n) ##1
        ((!raw_n && ce && clean_n) [*8]) |-> ##[0:300] (!clean_n || raw_n || !ce))
        else $error("long reset pulse not taken");
endmodule : reset_spike_filter

// >>> display_reset_sequencer.sv
// reset and power sequencer of the display module
// assumes hw_reset_n and cmd inputs synchronous to clk; nvm read takes one cycle
module display_reset_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned LOAD_CYCLES  = LOAD_CYC,
    parameter int unsigned BLANK_CYCLES = BLANK_CYC,
    parameter int unsigned WORDS        = NVM_WORDS
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       hw_reset_n,
    input  wire logic       sleep_out,
    input  wire logic [7:0] nvm_rdata,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_data,
    output logic [2:0]      nvm_addr,
    output logic            nvm_rd,
    output logic            panel_blank,
    output logic            settings_valid,
    output logic [7:0]      setting_word,
    output logic            cmd_accept,
    output logic [7:0]      cmd_out,
    output logic            ready
);
    // ********************
    // reset line filter
    // ********************
    logic clean_n;
    reset_spike_filter #(.FILT_CYC(FILTER_CYC)) u_filter (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .raw_n   (hw_reset_n),
        .clean_n (clean_n)
    );

    // ********************
    // sequence state
    // ********************
    seq_state_t  state;
    seq_state_t  next_state;
    logic        was_awake;
    logic [22:0] timer;
    logic [2:0]  idx;
    logic [7:0]  settings [WORDS];
    logic        loaded;

    // full cancel time counted from the line release
    function automatic logic [22:0] cancel_cycles(input logic awake);
        cancel_cycles = awake ? 23'(BLANK_CYCLES) : 23'(LOAD_CYCLES);
    endfunction : cancel_cycles

    // filter lag and exit states taken off, so the whole cancel ends on time
    wire [22:0] timer_limit = cancel_cycles(was_awake) - 23'(CANCEL_LAG_CYC);
    wire        tim_done    = timer >= timer_limit;
    wire load_end = idx == 3'(WORDS - 1);
    wire busy     = state != ST_RUN;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN:    if (!clean_n) next_state = ST_RESET;
            ST_RESET:  if (clean_n) next_state = ST_LOAD; // R4
            ST_LOAD:   if (!clean_n) next_state = ST_RESET;
                       else if (load_end) next_state = ST_BLANK;
            ST_BLANK:  if (!clean_n) next_state = ST_RESET;
                       else if (tim_done) next_state = ST_SETTLE; // R8
            ST_SETTLE: next_state = ST_RUN;
            default:   next_state = ST_RESET;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state     <= ST_RESET;
            was_awake <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            if (state == ST_RUN && !clean_n) begin
                was_awake <= sleep_out; // R6 R7
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer <= 23'h00_0000;
        end else if (ce) begin
            // idle timer kept at zero so a new limit never meets an old count
            if (!busy || state == ST_RESET) begin
                timer <= 23'h00_0000;
            end else if (!tim_done) begin
                timer <= timer + 23'h00_0001; // R5 R8
            end
        end
    end

    // ********************
    // settings reload
    // ********************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx    <= 3'h0;
            loaded <= 1'b0;
        end else if (ce) begin
            if (state != ST_LOAD) begin
                idx <= 3'h0;
            end else if (!load_end) begin
                idx <= idx + 3'h1;
            end
            if (state == ST_RESET) begin
                loaded <= 1'b0;
            end else if (state == ST_LOAD && load_end) begin
                loaded <= 1'b1; // R4
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce && state == ST_LOAD) begin
            settings[idx] <= nvm_rdata; // R4
        end
    end

    assign nvm_addr = idx;
    assign nvm_rd   = state == ST_LOAD;

    // ********************
    // outputs
    // ********************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            panel_blank    <= 1'b1;
            settings_valid <= 1'b0;
            setting_word   <= NVM_DEFAULT;
            cmd_out        <= 8'h00;
        end else if (ce) begin
            panel_blank    <= next_state != ST_RUN; // R6 R7
            settings_valid <= loaded;
            setting_word   <= loaded ? settings[0] : NVM_DEFAULT;
            if (cmd_valid && !busy) begin
                cmd_out <= cmd_data;
            end
        end
    end

    assign ready      = !busy;
    assign cmd_accept = cmd_valid && !busy && ce; // R11

    // ********************
    // cancel time watch
    // ********************
    logic        pin_d;
    logic        cancel_run;
    logic [22:0] cancel_cnt;

    // counts from the pin's own release, apart from the sequence timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_d      <= 1'b1;
            cancel_run <= 1'b0;
            cancel_cnt <= 23'h00_0000;
        end else if (ce) begin
            pin_d <= hw_reset_n;
            if (!hw_reset_n || !busy) begin
                cancel_run <= 1'b0;
                cancel_cnt <= 23'h00_0000;
            end else if (!pin_d) begin
                cancel_run <= 1'b1; // R8
                cancel_cnt <= 23'h00_0001;
            end else if (cancel_run) begin
                cancel_cnt <= cancel_cnt + 23'h00_0001;
            end
        end
    end

    // ********************
    // checks
    // ********************
    chk_cmd_blocked: assert property (@(posedge clk) disable iff (rst) // R11
        busy |-> !cmd_accept)
        else $error("command accepted during reset");
    chk_blank_reset: assert property (@(posedge clk) disable iff (rst) // R7
        (ce && state == ST_RESET) |=> panel_blank)
        else $error("panel not blank in reset");
    chk_reload_start: assert property (@(posedge clk) disable iff (rst) // R4
        (ce && state == ST_RESET && clean_n) |=> state == ST_LOAD)
        else $error("release did not start reload");
    chk_load_done: assert property (@(posedge clk) disable iff (rst) // R5
        (ce && state == ST_LOAD && load_end && clean_n) |=> loaded)
        else $error("settings load not finished");
    chk_cancel_len: assert property (@(posedge clk) disable iff (rst) // R8
        (state == ST_BLANK && tim_done && clean_n && ce) |=> state == ST_SETTLE)
        else $error("cancel time overrun");
    chk_awake_capture: assert property (@(posedge clk) disable iff (rst) // R6
        (ce && state == ST_RUN && !clean_n) |=> was_awake == $past(sleep_out))
        else $error("sleep state not captured");
    chk_ready_out: assert property (@(posedge clk) disable iff (rst) // R8
        (ce && state == ST_SETTLE) |=> (ready && !panel_blank) || !clean_n)
        else $error("not ready after cancel");
    chk_timer_cap: assert property (@(posedge clk) disable iff (rst) // R8
        timer <= timer_limit)
        else $error("timer beyond limit");
    chk_cancel_max: assert property (@(posedge clk) disable iff (rst) // R5 R8
        (ce && cancel_run) |-> cancel_cnt <= cancel_cycles(was_awake))
        else $error("reset cancel too long");
    chk_awake_cancel: assert property (@(posedge clk) disable iff (rst) // R6 R8
        (ce && $rose(ready) && cancel_run && was_awake) |-> cancel_cnt == cancel_cycles(1'b1))
        else $error("awake cancel time wrong");
    chk_settings_hold: assert property (@(posedge clk) disable iff (rst) // R4
        (ce && state == ST_SETTLE) |-> settings_valid)
        else $error("settings not loaded at cancel end");
    chk_cmd_capture: assert property (@(posedge clk) disable iff (rst) // R11
        cmd_accept |=> cmd_out == $past(cmd_data))
        else $error("accepted command not kept");

    cov_awake_reset:  cover property (@(posedge clk) state == ST_BLANK && was_awake);
    cov_asleep_reset: cover property (@(posedge clk) state == ST_BLANK && !was_awake);
    cov_cmd_taken:    cover property (@(posedge clk) cmd_accept);
    cov_cancel_done:  cover property (@(posedge clk) $rose(ready) && cancel_run);
endmodule : display_reset_sequencer

// >>> host_model.sv
// host side model: drives the reset line and the command port
// assumes drive_low is called at a rising edge; send aligns to the next edge
module host_model (
    input  wire logic       clk,
    input  wire logic       ready,
    output logic            hw_reset_n,
    output logic            cmd_valid,
    output logic [7:0]      cmd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hw_reset_n = 1'b1;
        cmd_valid  = 1'b0;
        cmd_data   = 8'h00;
    end
    // low for n cycles, optional short high glitch, then low again
    task automatic drive_low(input int n, input int glitch);
        hw_reset_n <= 1'b0;
        repeat (n) @(posedge clk);
        if (glitch > 0) begin
            hw_reset_n <= 1'b1;
            repeat (glitch) @(posedge clk);
            hw_reset_n <= 1'b0;
            repeat (n / 4) @(posedge clk);
        end
        hw_reset_n <= 1'b1;
    endtask : drive_low
    // two bytes back to back; patient host waits for ready first
    task automatic send(input logic [7:0] a, input logic [7:0] b, input bit patient);
        @(posedge clk);
        while (patient && ready !== 1'b1) @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_data  <= a;
        @(posedge clk);
        cmd_data  <= b;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_data  <= ~b;
    endtask : send
endmodule : host_model

// >>> tb_top.sv
// self-checking bench of the display reset sequencer
// assumes shortened load and blank counts; nvm word k reads 0xa8 + k
module tb_top
    import reset_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ************
    // bench
    // ************
    localparam int LD = 400;
    localparam int BL = 1000;
    localparam int SP = SPIKE_CYC;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       sleep_out = 1'b0;
    logic       hw_reset_n, cmd_valid, nvm_rd, panel_blank;
    logic       settings_valid, cmd_accept, ready;
    logic [7:0] cmd_data, nvm_rdata, setting_word, cmd_out;
    logic [2:0] nvm_addr;
    int         num_errors = 0, comparisons = 0, cyc = 0, n_acc = 0, n_rd = 0;
    assign nvm_rdata = {5'h15, nvm_addr};
    always #12.5 clk = ~clk;
    host_model host_model_inst (.clk(clk), .ready(ready), .hw_reset_n(hw_reset_n),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data));
    display_reset_sequencer #(.LOAD_CYCLES(LD), .BLANK_CYCLES(BL))
        display_reset_sequencer_inst (.clk(clk), .rst(rst), .ce(1'b1),
        .hw_reset_n(hw_reset_n), .sleep_out(sleep_out), .nvm_rdata(nvm_rdata),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data), .nvm_addr(nvm_addr), .nvm_rd(nvm_rd),
        .panel_blank(panel_blank), .settings_valid(settings_valid),
        .setting_word(setting_word), .cmd_accept(cmd_accept), .cmd_out(cmd_out),
        .ready(ready));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cmd_accept === 1'b1) n_acc <= n_acc + 1;
        if (nvm_rd === 1'b1) n_rd <= n_rd + 1;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_ready(output int n);
        n = 0;
        while (ready !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_ready
    task automatic reloaded;
        @(posedge clk);
        #1;
        check(panel_blank, 1'b0);
        check(settings_valid, 1'b1);
        check(setting_word, 8'ha8);
    endtask : reloaded
    task automatic power_up;
        int n;
        wait_ready(n);
        check(n <= LD, 1'b1);
        reloaded();
    endtask : power_up
    task automatic spike_and_cmds;
        int a;
        a = n_acc;
        @(posedge clk);
        host_model_inst.drive_low(SP - 1, 0);
        repeat (300) @(posedge clk);
        #1;
        check(ready, 1'b1);
        check(panel_blank, 1'b0);
        host_model_inst.send(8'h3c, 8'hc3, 1'b1);
        @(posedge clk);
        #1;
        check(n_acc, a + 2);
        check(cmd_out, 8'hc3);
    endtask : spike_and_cmds
    task automatic reset_cycle(input logic awake, input int glitch);
        int n, a, r;
        @(posedge clk);
        sleep_out <= awake;
        host_model_inst.drive_low(400, glitch);
        #1;
        check(panel_blank, 1'b1);
        check(ready, 1'b0);
        check(settings_valid, 1'b0);
        check(setting_word, NVM_DEFAULT);
        a = n_acc;
        r = n_rd;
        host_model_inst.send(8'h5a, 8'ha5, 1'b0);
        wait_ready(n);
        n = n + 3;
        check(n_acc, a);
        check(cmd_out, 8'hc3);
        check(n_rd - r, NVM_WORDS);
        if (awake) check(n, BL);
        else check(n <= LD, 1'b1);
        reloaded();
    endtask : reset_cycle
    task automatic give_verdict;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        power_up();
        spike_and_cmds();
        reset_cycle(1'b0, 50);
        reset_cycle(1'b1, 0);
        spike_and_cmds();
        give_verdict();
    end
endmodule : tb_top
